// ### rtl/vcc_field_counter.sv
`timescale 1ns/1ps
`default_nettype none
module vcc_field_counter #(
	parameter int WIDTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             field_odd,
	input  wire logic             any_capture,
	input  wire logic             clear,
	output logic      [WIDTH-1:0] count
);
	logic field_last;

	always_ff @(posedge clock) begin
		if (rst)
			field_last <= 1'b0;
		else
			field_last <= field_odd;
	end

	// Clear wins over a same-cycle count, since software asked for zero
	always_ff @(posedge clock) begin
		if (rst)
			count <= '0;
		else if (clear)
			count <= '0;
		else if (any_capture && (field_odd != field_last))
			count <= count + 1'b1;
	end
endmodule // vcc_field_counter
`default_nettype wire

// ### rtl/vcc_pkg.sv
package vcc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [11:0] CAPTURE_CONTROL_OFS = 12'h0dc;
	localparam logic [11:0] VBI_COUNT_LOW_OFS = 12'h0e0;
	localparam logic [11:0] VBI_DELAY_COUNT_HIGH_OFS = 12'h0e4;
	localparam logic [11:0] FIELD_TRANSITION_COUNTER_OFS = 12'h0e8;
	localparam logic [11:0] PLL_FRACTION_LOW_OFS = 12'h0f0;
	localparam logic [11:0] PLL_FRACTION_HIGH_OFS = 12'h0f4;
	localparam logic [11:0] PLL_DIVIDER_SETUP_OFS = 12'h0f8;
	localparam logic [11:0] DIGITAL_VIDEO_INPUT_FORMAT_OFS = 12'h0fc;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int CAP_EVEN_BIT = 0;
	localparam int CAP_ODD_BIT = 1;
	localparam int VBI_EVEN_BIT = 2;
	localparam int VBI_ODD_BIT = 3;
	localparam int DITHER_BIT = 4;
	localparam int PKT_HIGH_BIT = 0;
	localparam int EXTEND_BIT = 1;
	localparam int DELAY_LSB = 2;
	localparam int DELAY_W = 6;
	localparam int PLL_INT_W = 6;
	localparam int POST_DIV_BIT = 6;
	localparam int PRE_DIV_BIT = 7;
	localparam int FORMAT_W = 3;
	localparam int ALIGN_LSB = 3;
	localparam int SYNC_OE_BIT = 5;
	localparam int BYPASS_BIT = 6;
	localparam logic [2:0] FMT_OFF = 3'h0;
	localparam logic [2:0] FMT_EMBEDDED = 3'h1;
	localparam logic [2:0] FMT_EXT_HV = 3'h4;
	localparam logic [2:0] FMT_EXT_HF = 3'h5;
	localparam logic [9:0] EXTEND_LINES = 10'h00a;
	localparam logic [1:0] SAMPLES_PER_WORD_M1 = 2'h3;
	typedef enum logic [2:0] {
		VCC_IDLE = 3'b001,
		VCC_DELAY = 3'b010,
		VCC_GRAB = 3'b100
	} vcc_vbi_e;
endpackage

// ### rtl/vcc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module vcc_regs (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_rvalid,
	input  wire logic        field_odd,
	input  wire logic        vbi_line,
	input  wire logic        pixel_tick,
	input  wire logic        pixel_valid,
	input  wire logic        horizontal_reset_pulse,
	input  wire logic [9:0]  line_number,
	input  wire logic [9:0]  active_vertical_window_first,
	input  wire logic [9:0]  active_vertical_window_last,
	input  wire logic        hsync_gen,
	input  wire logic        vsync_gen,
	input  wire logic [1:0]  sample_phase,
	input  wire logic        hsync_pin_in,
	input  wire logic        vsync_pin_in,
	output logic             hsync_pin_out,
	output logic             hsync_pin_oe_n,
	output logic             vsync_pin_out,
	output logic             vsync_pin_oe_n,
	output logic             hsync_ext,
	output logic             vsync_ext,
	output logic             pixel_fifo_write,
	output logic             vbi_fifo_write,
	output logic             vbi_line_done,
	output logic             in_capture_region,
	output logic             dither_scope_select,
	output logic [15:0]      pll_fraction,
	output logic             pll_pre_divide_two,
	output logic             pll_post_divide_four,
	output logic [5:0]       pll_integer,
	output logic             pll_sleep,
	output logic             chroma_filter_bypass,
	output logic [1:0]       sync_sample_alignment,
	output logic [2:0]       digital_input_format_select,
	output logic             digital_input_enable,
	output logic             embedded_sync_mode,
	output logic             external_field_mode,
	output logic             format_reserved
);
	logic [7:0]          capture_control;
	logic [7:0]          vbi_count_low;
	logic [7:0]          vbi_delay_count_high;
	logic [7:0]          field_counter_value;
	logic [7:0]          pll_fraction_low;
	logic [7:0]          pll_fraction_high;
	logic [7:0]          pll_divider_setup;
	logic [7:0]          digital_video_input_format;
	logic                counter_clear;
	logic                any_capture;
	logic                field_vbi_on;
	logic [8:0]          packet_words;
	logic [5:0]          line_start_delay;
	logic [2:0]          horizontal_reset_pulse_sync;
	logic                horizontal_reset_pulse_trail;
	logic [1:0]          hpin_sync;
	logic [1:0]          vpin_sync;
	logic [5:0]          delay_left;
	logic [8:0]          words_done;
	logic [1:0]          sample_count;
	logic [9:0]          region_first;
	vcc_pkg::vcc_vbi_e   vbi_state;

	function automatic logic hit(input logic [11:0] ofs);
		hit = (reg_addr == ofs);
	endfunction

	function automatic logic [2:0] fmt_field(input logic [7:0] r);
		fmt_field = r[vcc_pkg::FORMAT_W-1:0];
	endfunction

	assign counter_clear = reg_write && hit(vcc_pkg::FIELD_TRANSITION_COUNTER_OFS);
	assign any_capture = |capture_control[vcc_pkg::DITHER_BIT-1:0];
	assign field_vbi_on = field_odd ? capture_control[vcc_pkg::VBI_ODD_BIT]
		: capture_control[vcc_pkg::VBI_EVEN_BIT];
	assign packet_words = {vbi_delay_count_high[vcc_pkg::PKT_HIGH_BIT], vbi_count_low};
	assign line_start_delay = vbi_delay_count_high[vcc_pkg::DELAY_LSB +: vcc_pkg::DELAY_W];
	assign horizontal_reset_pulse_trail = horizontal_reset_pulse_sync[2] && !horizontal_reset_pulse_sync[1];

	// Reserved capture bits are stored as written; software keeps them zero
	always_ff @(posedge clock) begin
		if (rst) begin
			capture_control <= vcc_pkg::REG_RESET;
			vbi_count_low <= vcc_pkg::REG_RESET;
			vbi_delay_count_high <= vcc_pkg::REG_RESET;
			pll_fraction_low <= vcc_pkg::REG_RESET;
			pll_fraction_high <= vcc_pkg::REG_RESET;
			pll_divider_setup <= vcc_pkg::REG_RESET;
			digital_video_input_format <= vcc_pkg::REG_RESET;
		end else if (reg_write) begin
			if (hit(vcc_pkg::CAPTURE_CONTROL_OFS))
				capture_control <= reg_wdata;
			if (hit(vcc_pkg::VBI_COUNT_LOW_OFS))
				vbi_count_low <= reg_wdata;
			if (hit(vcc_pkg::VBI_DELAY_COUNT_HIGH_OFS))
				vbi_delay_count_high <= reg_wdata;
			if (hit(vcc_pkg::PLL_FRACTION_LOW_OFS))
				pll_fraction_low <= reg_wdata;
			if (hit(vcc_pkg::PLL_FRACTION_HIGH_OFS))
				pll_fraction_high <= reg_wdata;
			if (hit(vcc_pkg::PLL_DIVIDER_SETUP_OFS))
				pll_divider_setup <= reg_wdata;
			if (hit(vcc_pkg::DIGITAL_VIDEO_INPUT_FORMAT_OFS))
				digital_video_input_format <= reg_wdata;
		end
	end

	vcc_field_counter #(
		.WIDTH(8)
	) u_field_counter (
		.clock      (clock),
		.rst        (rst),
		.field_odd  (field_odd),
		.any_capture(any_capture),
		.clear      (counter_clear),
		.count      (field_counter_value)
	);

	// Read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clock) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
			if (!reg_read)
				reg_rdata <= 8'h00;
			else if (hit(vcc_pkg::CAPTURE_CONTROL_OFS))
				reg_rdata <= capture_control;
			else if (hit(vcc_pkg::VBI_COUNT_LOW_OFS))
				reg_rdata <= vbi_count_low;
			else if (hit(vcc_pkg::VBI_DELAY_COUNT_HIGH_OFS))
				reg_rdata <= vbi_delay_count_high;
			else if (hit(vcc_pkg::FIELD_TRANSITION_COUNTER_OFS))
				reg_rdata <= field_counter_value;
			else if (hit(vcc_pkg::PLL_FRACTION_LOW_OFS))
				reg_rdata <= pll_fraction_low;
			else if (hit(vcc_pkg::PLL_FRACTION_HIGH_OFS))
				reg_rdata <= pll_fraction_high;
			else if (hit(vcc_pkg::PLL_DIVIDER_SETUP_OFS))
				reg_rdata <= pll_divider_setup;
			else if (hit(vcc_pkg::DIGITAL_VIDEO_INPUT_FORMAT_OFS))
				reg_rdata <= digital_video_input_format;
			else
				reg_rdata <= 8'h00;
		end
	end

	// Pin inputs pass two flops before use
	always_ff @(posedge clock) begin
		if (rst) begin
			horizontal_reset_pulse_sync <= 3'h0;
			hpin_sync <= 2'h0;
			vpin_sync <= 2'h0;
		end else begin
			horizontal_reset_pulse_sync <= {horizontal_reset_pulse_sync[1:0], horizontal_reset_pulse};
			hpin_sync <= {hpin_sync[0], hsync_pin_in};
			vpin_sync <= {vpin_sync[0], vsync_pin_in};
		end
	end

	// Pixel writes allowed only in a field whose capture bit is set
	always_ff @(posedge clock) begin
		if (rst)
			pixel_fifo_write <= 1'b0;
		else
			pixel_fifo_write <= pixel_valid && (field_odd ? capture_control[vcc_pkg::CAP_ODD_BIT]
				: capture_control[vcc_pkg::CAP_EVEN_BIT]);
	end

	// VBI line grab: delay, then whole words of four samples
	always_ff @(posedge clock) begin
		if (rst) begin
			vbi_state <= vcc_pkg::VCC_IDLE;
			delay_left <= 6'h00;
			words_done <= 9'h000;
			sample_count <= 2'h0;
			vbi_fifo_write <= 1'b0;
			vbi_line_done <= 1'b0;
		end else begin
			vbi_fifo_write <= 1'b0;
			vbi_line_done <= 1'b0;
			unique case (vbi_state)
				vcc_pkg::VCC_IDLE: begin
					words_done <= 9'h000;
					sample_count <= 2'h0;
					// Delay reloaded while idle; a rewrite applies from the next line
					delay_left <= line_start_delay;
					if (horizontal_reset_pulse_trail && vbi_line && field_vbi_on) begin
						if (line_start_delay == 6'h00)
							vbi_state <= vcc_pkg::VCC_GRAB;
						else
							vbi_state <= vcc_pkg::VCC_DELAY;
					end
				end
				vcc_pkg::VCC_DELAY: begin
					if (pixel_tick) begin
						delay_left <= delay_left - 6'h01;
						if (delay_left == 6'h01)
							vbi_state <= vcc_pkg::VCC_GRAB;
					end
				end
				vcc_pkg::VCC_GRAB: begin
					// Zero length or a dropped enable ends the line at once
					if (packet_words == 9'h000 || !field_vbi_on) begin
						vbi_state <= vcc_pkg::VCC_IDLE;
						vbi_line_done <= 1'b1;
					end else if (pixel_tick) begin
						sample_count <= sample_count + 2'h1;
						if (sample_count == vcc_pkg::SAMPLES_PER_WORD_M1) begin
							vbi_fifo_write <= 1'b1;
							words_done <= words_done + 9'h001;
							if (words_done + 9'h001 == packet_words) begin
								vbi_state <= vcc_pkg::VCC_IDLE;
								vbi_line_done <= 1'b1;
							end
						end
					end
				end
			endcase
		end
	end

	// Window start pulled ten lines earlier; clamps at line zero
	always_comb begin
		region_first = active_vertical_window_first;
		if (vbi_delay_count_high[vcc_pkg::EXTEND_BIT]) begin
			if (active_vertical_window_first >= vcc_pkg::EXTEND_LINES)
				region_first = active_vertical_window_first - vcc_pkg::EXTEND_LINES;
			else
				region_first = 10'h000;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			in_capture_region <= 1'b0;
			dither_scope_select <= 1'b0;
		end else begin
			in_capture_region <= (line_number >= region_first)
				&& (line_number <= active_vertical_window_last);
			dither_scope_select <= capture_control[vcc_pkg::DITHER_BIT];
		end
	end

	// PLL controls; out-of-range integer passed through, zero means sleep
	// Sleep flag kept beside the integer so the PLL needs no decode of its own
	always_ff @(posedge clock) begin
		if (rst) begin
			pll_fraction <= 16'h0000;
			pll_pre_divide_two <= 1'b0;
			pll_post_divide_four <= 1'b0;
			pll_integer <= 6'h00;
			pll_sleep <= 1'b1;
		end else begin
			pll_fraction <= {pll_fraction_high, pll_fraction_low};
			pll_pre_divide_two <= pll_divider_setup[vcc_pkg::PRE_DIV_BIT];
			pll_post_divide_four <= pll_divider_setup[vcc_pkg::POST_DIV_BIT];
			pll_integer <= pll_divider_setup[vcc_pkg::PLL_INT_W-1:0];
			pll_sleep <= (pll_divider_setup[vcc_pkg::PLL_INT_W-1:0] == 6'h00);
		end
	end

	// Digital input format decode
	always_ff @(posedge clock) begin
		if (rst) begin
			chroma_filter_bypass <= 1'b0;
			sync_sample_alignment <= 2'h0;
			digital_input_format_select <= 3'h0;
			digital_input_enable <= 1'b0;
			embedded_sync_mode <= 1'b0;
			external_field_mode <= 1'b0;
			format_reserved <= 1'b0;
		end else begin
			chroma_filter_bypass <= digital_video_input_format[vcc_pkg::BYPASS_BIT];
			sync_sample_alignment <= digital_video_input_format[vcc_pkg::ALIGN_LSB +: 2];
			digital_input_format_select <= fmt_field(digital_video_input_format);
			digital_input_enable <= fmt_field(digital_video_input_format) == vcc_pkg::FMT_EMBEDDED
				|| fmt_field(digital_video_input_format) == vcc_pkg::FMT_EXT_HV
				|| fmt_field(digital_video_input_format) == vcc_pkg::FMT_EXT_HF;
			embedded_sync_mode <= fmt_field(digital_video_input_format) == vcc_pkg::FMT_EMBEDDED;
			external_field_mode <= fmt_field(digital_video_input_format) == vcc_pkg::FMT_EXT_HF;
			format_reserved <= fmt_field(digital_video_input_format) != vcc_pkg::FMT_OFF
				&& fmt_field(digital_video_input_format) != vcc_pkg::FMT_EMBEDDED
				&& fmt_field(digital_video_input_format) != vcc_pkg::FMT_EXT_HV
				&& fmt_field(digital_video_input_format) != vcc_pkg::FMT_EXT_HF;
		end
	end

	// Sync pins: pin output levels change only on the chosen sample phase; enables change on any phase
	always_ff @(posedge clock) begin
		if (rst) begin
			hsync_pin_out <= 1'b0;
			vsync_pin_out <= 1'b0;
			hsync_pin_oe_n <= 1'b1;
			vsync_pin_oe_n <= 1'b1;
			hsync_ext <= 1'b0;
			vsync_ext <= 1'b0;
		end else begin
			hsync_pin_oe_n <= !digital_video_input_format[vcc_pkg::SYNC_OE_BIT];
			vsync_pin_oe_n <= !digital_video_input_format[vcc_pkg::SYNC_OE_BIT];
			// Registered alignment, so a rewrite takes effect one edge later
			if (sample_phase == sync_sample_alignment) begin
				hsync_pin_out <= hsync_gen;
				vsync_pin_out <= vsync_gen;
			end
			// Inputs seen only while the pins are not driven
			hsync_ext <= !digital_video_input_format[vcc_pkg::SYNC_OE_BIT] && hpin_sync[1];
			vsync_ext <= !digital_video_input_format[vcc_pkg::SYNC_OE_BIT] && vpin_sync[1];
		end
	end
endmodule // vcc_regs
`default_nettype wire

// ### tb/vcc_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vcc_regs_monitor (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic [11:0] reg_addr,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_rvalid,
	input wire logic        pixel_valid,
	input wire logic [1:0]  sample_phase,
	input wire logic        hsync_pin_out,
	input wire logic        hsync_pin_oe_n,
	input wire logic        pixel_fifo_write,
	input wire logic [15:0] pll_fraction,
	input wire logic        pll_pre_divide_two,
	input wire logic        pll_post_divide_four,
	input wire logic [5:0]  pll_integer,
	input wire logic        pll_sleep,
	input wire logic        chroma_filter_bypass,
	input wire logic [1:0]  sync_sample_alignment,
	input wire logic [2:0]  digital_input_format_select,
	input wire logic        digital_input_enable,
	input wire logic        embedded_sync_mode,
	input wire logic        external_field_mode,
	input wire logic        format_reserved
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence wr(a);
		reg_write && reg_addr == a;
	endsequence
	read_answer_a: assert property (reg_read |=> reg_rvalid) else $error("read not answered");
	frac_low_a: assert property (wr(12'h0f0) |-> ##2 pll_fraction[7:0] == $past(reg_wdata, 2))
		else $error("fraction low byte wrong");
	frac_high_a: assert property (wr(12'h0f4) |-> ##2 pll_fraction[15:8] == $past(reg_wdata, 2))
		else $error("fraction high byte wrong");
	div_setup_a: assert property (wr(12'h0f8)
		|-> ##2 {pll_pre_divide_two, pll_post_divide_four, pll_integer} == $past(reg_wdata, 2))
		else $error("divider wrong");
	sleep_map_a: assert property (pll_sleep == (pll_integer == 6'h00))
		else $error("sleep mismatch");
	fmt_fields_a: assert property (wr(12'h0fc) |-> ##2 chroma_filter_bypass == $past(reg_wdata[6], 2)
		&& hsync_pin_oe_n == !$past(reg_wdata[5], 2) && sync_sample_alignment == $past(reg_wdata[4:3], 2)
		&& digital_input_format_select == $past(reg_wdata[2:0], 2)) else $error("format fields wrong");
	fmt_decode_a: assert property (digital_input_enable == (digital_input_format_select inside {3'h1, 3'h4, 3'h5})
		&& embedded_sync_mode == (digital_input_format_select == 3'h1)
		&& external_field_mode == (digital_input_format_select == 3'h5)
		&& format_reserved == !(digital_input_format_select inside {3'h0, 3'h1, 3'h4, 3'h5}))
		else $error("format decode wrong");
	pixel_gate_a: assert property (pixel_fifo_write |-> $past(pixel_valid))
		else $error("pixel write without request");
	sync_align_a: assert property ($changed(hsync_pin_out) && !$past(rst)
		|-> $past(sample_phase) == $past(sync_sample_alignment)) else $error("sync moved off phase");
endmodule // vcc_regs_monitor
bind vcc_regs vcc_regs_monitor i_vcc_regs_monitor (.clock, .rst, .reg_addr, .reg_write, .reg_read, .reg_wdata,
	.reg_rvalid, .pixel_valid, .sample_phase, .hsync_pin_out, .hsync_pin_oe_n, .pixel_fifo_write, .pll_fraction,
	.pll_pre_divide_two, .pll_post_divide_four, .pll_integer, .pll_sleep, .chroma_filter_bypass,
	.sync_sample_alignment, .digital_input_format_select, .digital_input_enable, .embedded_sync_mode,
	.external_field_mode, .format_reserved);
`default_nettype wire

// ### tb/video_capture_control_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module video_capture_control_regs_test;
	logic        clock = 0, rst = 1, reg_write = 0, reg_read = 0, field_odd = 0, vbi_line = 0;
	logic        pixel_tick = 0, pixel_valid = 0, horizontal_reset_pulse = 0, sgen = 0;
	logic [11:0] reg_addr = 0;
	logic [7:0]  reg_wdata = 0, reg_rdata, rd;
	logic [1:0]  sample_phase = 0, sync_sample_alignment;
	logic [2:0]  digital_input_format_select;
	logic [5:0]  pll_integer;
	logic [15:0] pll_fraction;
	logic        reg_rvalid, hsync_pin_out, hsync_pin_oe_n, pixel_fifo_write, vbi_fifo_write, vbi_line_done;
	logic        dither_scope_select, pll_pre_divide_two, pll_post_divide_four, pll_sleep, chroma_filter_bypass;
	logic        digital_input_enable, embedded_sync_mode, external_field_mode, format_reserved;
	logic [9:0]  line = 0, win_first = 0, win_last = 0;
	logic        hpin = 0, vpin = 0, in_capture_region, hsync_ext, vsync_ext, vsync_pin_out, vsync_pin_oe_n;
	int          n_mismatch = 0, check_count = 0, words, dones, done_at;
	vcc_regs i_vcc_regs (.clock, .rst, .reg_addr, .reg_write, .reg_read, .reg_wdata, .reg_rdata, .reg_rvalid,
		.field_odd, .vbi_line, .pixel_tick, .pixel_valid, .horizontal_reset_pulse, .line_number(line),
		.active_vertical_window_first(win_first), .active_vertical_window_last(win_last), .hsync_gen(sgen),
		.vsync_gen(sgen), .sample_phase, .hsync_pin_in(hpin), .vsync_pin_in(vpin), .hsync_pin_out,
		.hsync_pin_oe_n, .vsync_pin_out, .vsync_pin_oe_n, .hsync_ext, .vsync_ext, .pixel_fifo_write,
		.vbi_fifo_write, .vbi_line_done, .in_capture_region, .dither_scope_select, .pll_fraction,
		.pll_pre_divide_two, .pll_post_divide_four, .pll_integer, .pll_sleep, .chroma_filter_bypass,
		.sync_sample_alignment, .digital_input_format_select, .digital_input_enable, .embedded_sync_mode,
		.external_field_mode, .format_reserved);
	always #25 clock = ~clock;
	task final_report;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_write = 1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clock);
		reg_write = 0;
		// Derived outputs follow the register one edge later
		@(negedge clock);
	endtask
	task rdb(input logic [11:0] a);
		@(negedge clock);
		reg_read = 1;
		reg_addr = a;
		@(negedge clock);
		reg_read = 0;
		rd = reg_rdata;
		chk("rvalid", 1, reg_rvalid);
	endtask
	task tog(input int n);
		repeat (n) begin
			@(negedge clock);
			field_odd = ~field_odd;
		end
		repeat (2) @(negedge clock);
	endtask
	task t_reset;
		for (int a = 12'h0dc; a <= 12'h0fc; a += 4) begin
			rdb(a[11:0]);
			chk("reset value", 0, rd);
		end
		chk("sleep at reset", 1, pll_sleep);
		chk("oe_n at reset", 1, hsync_pin_oe_n);
	endtask
	task t_regs;
		// Upper capture bits kept zero as software must
		wr(12'h0dc, 8'h1f);
		rdb(12'h0dc);
		chk("capture", 8'h1f, rd);
		chk("dither", 1, dither_scope_select);
		wr(12'h0e0, 8'ha5);
		wr(12'h0e4, 8'h5b);
		rdb(12'h0e0);
		chk("count low", 8'ha5, rd);
		rdb(12'h0e4);
		chk("delay high", 8'h5b, rd);
		wr(12'h0f0, 8'h34);
		wr(12'h0f4, 8'h12);
		chk("fraction", 16'h1234, pll_fraction);
		wr(12'h0f8, 8'hc6);
		chk("divider", 8'hc6, {pll_pre_divide_two, pll_post_divide_four, pll_integer});
		chk("awake", 0, pll_sleep);
		wr(12'h0f8, 8'h00);
		chk("asleep", 1, pll_sleep);
		wr(12'h0fc, 8'h7d);
		chk("bypass", 1, chroma_filter_bypass);
		chk("oe_n driving", 0, hsync_pin_oe_n);
		chk("alignment", 3, sync_sample_alignment);
		wr(12'h0ec, 8'hff);
		rdb(12'h0ec);
		chk("unmapped", 0, rd);
		for (int i = 0; i < 8; i++) begin
			wr(12'h0fc, 8'(i));
			chk("decode", {i inside {1, 4, 5}, i == 1, i == 5, !(i inside {0, 1, 4, 5})},
				{digital_input_enable, embedded_sync_mode, external_field_mode, format_reserved});
		end
	endtask
	task t_count;
		wr(12'h0dc, 8'h01);
		wr(12'h0e8, 8'hff);
		tog(3);
		rdb(12'h0e8);
		chk("counted", 3, rd);
		wr(12'h0e8, 8'h5a);
		rdb(12'h0e8);
		chk("cleared", 0, rd);
		wr(12'h0dc, 8'h00);
		tog(4);
		rdb(12'h0e8);
		chk("idle count", 0, rd);
		wr(12'h0dc, 8'h02);
		tog(257);
		rdb(12'h0e8);
		chk("wrapped", 1, rd);
	endtask
	task t_pixel;
		wr(12'h0dc, 8'h02);
		for (int f = 0; f < 2; f++) begin
			@(negedge clock);
			field_odd = f[0];
			pixel_valid = 1;
			@(negedge clock);
			pixel_valid = 0;
			chk("pixel write", f, pixel_fifo_write);
		end
		wr(12'h0fc, 8'h18);
		sgen = 1;
		sample_phase = 2;
		hpin = 1;
		vpin = 1;
		repeat (3) @(negedge clock);
		chk("sync held", 0, hsync_pin_out);
		chk("hsync input", 1, hsync_ext);
		chk("vsync input", 1, vsync_ext);
		sample_phase = 3;
		repeat (3) @(negedge clock);
		chk("sync aligned", 1, hsync_pin_out);
		wr(12'h0fc, 8'h38);
		chk("vsync driving", 0, vsync_pin_oe_n);
		chk("vsync out", 1, vsync_pin_out);
		chk("input masked", 0, hsync_ext);
	endtask
	task t_region;
		win_first = 10'h020;
		win_last = 10'h040;
		line = 10'h017;
		repeat (2) @(negedge clock);
		chk("region base", 0, in_capture_region);
		wr(12'h0e4, 8'h02);
		chk("region extended", 1, in_capture_region);
		line = 10'h016;
		repeat (2) @(negedge clock);
		chk("region first line", 1, in_capture_region);
		line = 10'h015;
		repeat (2) @(negedge clock);
		chk("region before", 0, in_capture_region);
	endtask
	task t_vbi;
		wr(12'h0dc, 8'h08);
		wr(12'h0e0, 8'h02);
		wr(12'h0e4, 8'h04);
		for (int f = 1; f >= 0; f--) begin
			@(negedge clock);
			field_odd = f[0];
			vbi_line = 1;
			horizontal_reset_pulse = 1;
			repeat (3) @(negedge clock);
			horizontal_reset_pulse = 0;
			pixel_tick = 1;
			words = 0;
			dones = 0;
			done_at = 0;
			for (int k = 1; k <= 40; k++) begin
				@(negedge clock);
				words += vbi_fifo_write;
				dones += vbi_line_done;
				if (vbi_line_done === 1'b1)
					done_at = k;
			end
			pixel_tick = 0;
			vbi_line = 0;
			chk("vbi words", 2 * f, 16'(words));
			chk("vbi done", f, 16'(dones));
			// Three edges to see the pulse end, one delay tick, four ticks a word
			chk("vbi done cycle", f * (3 + 1 + 4 * 2), 16'(done_at));
		end
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		final_report;
	end
	initial begin
		repeat (10) @(negedge clock);
		rst = 0;
		t_reset;
		t_regs;
		t_count;
		t_pixel;
		t_vbi;
		t_region;
		final_report;
	end
endmodule // video_capture_control_regs_test
`default_nettype wire
